// ### adcrd_pkg.sv
// Shared constants, types and helpers for the converter readout control
package adcrd_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  // System clock rate in Hz
  localparam longint unsigned CLK_HZ = 64'd100_000_000;
  // Power-up calibration until first result, in ms
  localparam longint unsigned PWRUP_MS = 64'd350;
  // Result rate in samples per second
  localparam longint unsigned CONV_SPS = 64'd15;
  // Self-calibration duration, in ms
  localparam longint unsigned CAL_MS = 64'd200;
  // Result update period before each new result, in us (least)
  localparam longint unsigned UPD_US = 64'd100;
  // High hold on the shift clock that enters sleep, in us (least)
  localparam longint unsigned SLEEP_US = 64'd100;
  // Derived cycle counts (least times round up)
  localparam int unsigned PWRUP_CYC = 32'(PWRUP_MS * CLK_HZ / 64'd1000);
  localparam int unsigned CONV_CYC = 32'(CLK_HZ / CONV_SPS);
  localparam int unsigned CAL_CYC = 32'(CAL_MS * CLK_HZ / 64'd1000);
  localparam int unsigned UPD_CYC =
    32'((UPD_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);
  localparam int unsigned SLEEP_CYC =
    32'((SLEEP_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);

  // ****************************************************************
  // Widths, codes and bit positions
  // ****************************************************************
  localparam int unsigned DATA_W = 24;   // Result word width
  localparam int unsigned RAW_W = 26;    // Filter output width
  localparam int unsigned EW = 4;        // Edge pointer width
  localparam int unsigned CNT_W = 26;    // State timer width
  localparam int unsigned HI_W = 16;     // High-hold timer width
  localparam int unsigned BC_W = 6;      // Edge count since ready
  localparam logic [4:0] IDX_MSB = 5'h17;            // Result MSB index
  localparam logic [BC_W-1:0] RISE_FORCE = 6'h18;    // 25th rising edge
  localparam logic [BC_W-1:0] FALL_CAL = 6'h19;      // Before 26th fall
  localparam logic [BC_W-1:0] RISE_SLP_CAL = 6'h1A;  // 25 pulses, then high
  localparam logic [BC_W-1:0] BC_MAX = 6'h3F;
  localparam logic [DATA_W-1:0] CODE_POS_FS = 24'h7F_FFFF;
  localparam logic [DATA_W-1:0] CODE_NEG_FS = 24'h80_0000;
  localparam logic signed [RAW_W-1:0] RAW_POS_FS = 26'sh7F_FFFF;
  localparam logic signed [RAW_W-1:0] RAW_NEG_FS = -26'sh80_0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_PWRUP,
    ST_CAL,
    ST_RUN,
    ST_SLEEP
  } adcrd_state_t;

  // Edge pointers of the shift clock, gray coded
  typedef struct packed {
    logic [EW-1:0] rise;
    logic [EW-1:0] fall;
  } adcrd_edge_t;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [EW-1:0] bin2gray(input logic [EW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [EW-1:0] gray2bin(input logic [EW-1:0] g);
    logic [EW-1:0] b;
    b = '0;
    for (int i = EW - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == EW - 1) ? 1'b0 : b[i+1]);
    end
    return b;
  endfunction

  // Clip the filter output to the two's complement result range
  function automatic logic [DATA_W-1:0] sat_code(
      input logic signed [RAW_W-1:0] raw);
    if (raw > RAW_POS_FS) begin
      return CODE_POS_FS;
    end else if (raw < RAW_NEG_FS) begin
      return CODE_NEG_FS;
    end
    return raw[DATA_W-1:0];
  endfunction

endpackage

// ### adcrd_sync.sv
// Two-stage synchroniser for a bus of gray-coded pointer bits
`timescale 1ns/100ps
module adcrd_sync #(
  parameter int unsigned W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ****************************************************************
  // Synchroniser stages
  // ****************************************************************
  logic [W-1:0] meta_q; // First stage, read only by the second

  // Two flops in series on the destination clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // adcrd_sync

// ### adcrd_top.sv
// Two-wire readout, calibration and sleep control of the converter
`timescale 1ns/100ps
// Overview of operation
// - Self-calibrate at power-up, then signal ready low
// - First result about 350 ms after power-up
// - Result is 24-bit two's complement word
// - Clip results at positive and negative full scale
// - Convert continuously, shift result out MSB first
// - Output holds last bit until update drives high
// - 25th rising edge forces output high
// - Falling edge of 26th pulse starts calibration
// - Ready low when calibration ends, data valid
// - Shift clock held high after ready enters sleep
// - Output high in sleep; clock low wakes
// - 25 bits before sleep gives calibration on wake
// - Wake starts single conversion; high re-sleeps
// - Common wakeup starts sampling on a fixed cycle
// - Output updates on each of the first 25 rising shift clock edges
// - Result rate 15 per second, scales with clock
module adcrd_top #(
  parameter int unsigned PWRUP_CYC = adcrd_pkg::PWRUP_CYC,
  parameter int unsigned CONV_CYC = adcrd_pkg::CONV_CYC,
  parameter int unsigned CAL_CYC = adcrd_pkg::CAL_CYC,
  parameter int unsigned UPD_CYC = adcrd_pkg::UPD_CYC,
  parameter int unsigned SLEEP_CYC = adcrd_pkg::SLEEP_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic [adcrd_pkg::RAW_W-1:0] raw_sample,
  output logic ready_and_serial_out,
  output logic conv_start_q,
  output logic sleep_q,
  output logic cal_busy_q
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic link_clr_n_q;                          // Clear for link flops
  logic [adcrd_pkg::EW-1:0] rise_gray_q;       // Rising edge pointer
  logic [adcrd_pkg::EW-1:0] fall_gray_q;       // Falling edge pointer
  adcrd_pkg::adcrd_edge_t edge_link;           // Pointers at the link
  adcrd_pkg::adcrd_edge_t edge_sync;           // Pointers in clk domain
  logic [adcrd_pkg::EW-1:0] rise_seen_q;       // Rising edges handled
  logic [adcrd_pkg::EW-1:0] fall_seen_q;       // Falling edges handled
  logic sclk_hi;                               // Tracked clock level
  logic rise_ev;                               // One rising edge now
  logic fall_ev;                               // One falling edge now
  adcrd_pkg::adcrd_state_t state_q, state_d;   // Control state
  logic [adcrd_pkg::CNT_W-1:0] cnt_q;          // State timer
  logic cnt_clr;                               // Restart state timer
  logic [adcrd_pkg::HI_W-1:0] hi_cnt_q;        // High-hold timer
  logic [adcrd_pkg::BC_W-1:0] rise_cnt_q;      // Rises since ready
  logic [adcrd_pkg::BC_W-1:0] fall_cnt_q;      // Falls since ready
  logic [adcrd_pkg::DATA_W-1:0] res_q;         // Result being read
  logic data_ok_q;                             // Result may be read
  logic got_rdy_q;                             // Ready seen in this run
  logic cal_on_wake_q;                         // Calibrate after wake
  logic pwrup_done, cal_done, load_ev, upd_ev;
  logic load_now, cal_req, sleep_ev, wake_ev;

  // ****************************************************************
  // Link clock domain
  // ****************************************************************
  // Clear for the link flops; host holds the clock low meanwhile
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link_clr_n_q <= 1'b0;
    end else begin
      link_clr_n_q <= 1'b1;
    end
  end

  always_ff @(posedge sclk or negedge link_clr_n_q) begin
    if (!link_clr_n_q) begin
      rise_gray_q <= '0;
    end else begin
      rise_gray_q <= adcrd_pkg::bin2gray(
        adcrd_pkg::gray2bin(rise_gray_q) + 4'h1);
    end
  end

  always_ff @(negedge sclk or negedge link_clr_n_q) begin
    if (!link_clr_n_q) begin
      fall_gray_q <= '0;
    end else begin
      fall_gray_q <= adcrd_pkg::bin2gray(
        adcrd_pkg::gray2bin(fall_gray_q) + 4'h1);
    end
  end

  assign edge_link.rise = rise_gray_q;
  assign edge_link.fall = fall_gray_q;

  // Gray pointers cross into the system clock domain
  adcrd_sync #(
    .W($bits(adcrd_pkg::adcrd_edge_t))
  ) u_edge_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(edge_link),
    .q(edge_sync)
  );

  // ****************************************************************
  // Edge events in the system clock domain
  // ****************************************************************
  // Level high once more rises than falls were handled
  assign sclk_hi = (rise_seen_q != fall_seen_q);
  // Rises and falls alternate, so the level picks the next one
  assign rise_ev = !sclk_hi &&
    (adcrd_pkg::gray2bin(edge_sync.rise) != rise_seen_q);
  assign fall_ev = sclk_hi &&
    (adcrd_pkg::gray2bin(edge_sync.fall) != fall_seen_q);

  // Handled-edge counters
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rise_seen_q <= '0;
      fall_seen_q <= '0;
    end else begin
      if (rise_ev) begin
        rise_seen_q <= rise_seen_q + 4'h1;
      end
      if (fall_ev) begin
        fall_seen_q <= fall_seen_q + 4'h1;
      end
    end
  end

  // ****************************************************************
  // Control events
  // ****************************************************************
  assign pwrup_done = (state_q == adcrd_pkg::ST_PWRUP) &&
    (cnt_q == adcrd_pkg::CNT_W'(PWRUP_CYC - 1));
  assign cal_done = (state_q == adcrd_pkg::ST_CAL) &&
    (cnt_q == adcrd_pkg::CNT_W'(CAL_CYC - 1));
  assign load_ev = (state_q == adcrd_pkg::ST_RUN) &&
    (cnt_q == adcrd_pkg::CNT_W'(CONV_CYC - 1));
  assign upd_ev = (state_q == adcrd_pkg::ST_RUN) &&
    (cnt_q == adcrd_pkg::CNT_W'(CONV_CYC - UPD_CYC - 1));
  assign load_now = pwrup_done || cal_done || load_ev;
  assign cal_req = (state_q == adcrd_pkg::ST_RUN) && data_ok_q &&
    fall_ev && (fall_cnt_q == adcrd_pkg::FALL_CAL);
  assign sleep_ev = (state_q == adcrd_pkg::ST_RUN) && got_rdy_q &&
    sclk_hi && (hi_cnt_q == adcrd_pkg::HI_W'(SLEEP_CYC - 1));
  assign wake_ev = (state_q == adcrd_pkg::ST_SLEEP) && fall_ev;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Transitions and timer restart
  always_comb begin
    state_d = state_q;
    cnt_clr = 1'b0;
    case (state_q)
      adcrd_pkg::ST_PWRUP: begin
        if (pwrup_done) begin
          state_d = adcrd_pkg::ST_RUN;
          cnt_clr = 1'b1;
        end
      end
      adcrd_pkg::ST_CAL: begin
        if (cal_done) begin
          state_d = adcrd_pkg::ST_RUN;
          cnt_clr = 1'b1;
        end
      end
      adcrd_pkg::ST_RUN: begin
        if (cal_req) begin
          state_d = adcrd_pkg::ST_CAL;
          cnt_clr = 1'b1;
        end else if (sleep_ev) begin
          state_d = adcrd_pkg::ST_SLEEP;
          cnt_clr = 1'b1;
        end else if (load_ev) begin
          cnt_clr = 1'b1;
        end
      end
      adcrd_pkg::ST_SLEEP: begin
        if (wake_ev) begin
          state_d = cal_on_wake_q ? adcrd_pkg::ST_CAL : adcrd_pkg::ST_RUN;
          cnt_clr = 1'b1;
        end
      end
      default: begin
        state_d = adcrd_pkg::ST_PWRUP;
        cnt_clr = 1'b1;
      end
    endcase
  end

  // State register and timer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= adcrd_pkg::ST_PWRUP;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      // timer runs in every state but sleep
      if (cnt_clr || (state_q == adcrd_pkg::ST_SLEEP)) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // High-hold timer, only counts while converting
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hi_cnt_q <= '0;
    end else if (sclk_hi && (state_q == adcrd_pkg::ST_RUN)) begin
      hi_cnt_q <= hi_cnt_q + 1'b1;
    end else begin
      hi_cnt_q <= '0;
    end
  end

  // ****************************************************************
  // Result and readout tracking
  // ****************************************************************
  // clipped result capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      res_q <= '0;
    end else if (load_now) begin
      res_q <= adcrd_pkg::sat_code(raw_sample);
    end
  end

  // Readable window from ready to update start
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_ok_q <= 1'b0;
      got_rdy_q <= 1'b0;
    end else begin
      if (load_now) begin
        data_ok_q <= 1'b1;
      end else if (upd_ev || cal_req || sleep_ev || wake_ev) begin
        data_ok_q <= 1'b0;
      end
      if (load_now) begin
        got_rdy_q <= 1'b1;
      end else if (state_d != adcrd_pkg::ST_RUN) begin
        got_rdy_q <= 1'b0;
      end
    end
  end

  // Edge counts since the last ready, saturating
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rise_cnt_q <= '0;
      fall_cnt_q <= '0;
    end else if (load_now || wake_ev) begin
      rise_cnt_q <= '0;
      fall_cnt_q <= '0;
    end else begin
      if (rise_ev && data_ok_q && (rise_cnt_q != adcrd_pkg::BC_MAX)) begin
        rise_cnt_q <= rise_cnt_q + 1'b1;
      end
      if (fall_ev && data_ok_q && (fall_cnt_q != adcrd_pkg::BC_MAX)) begin
        fall_cnt_q <= fall_cnt_q + 1'b1;
      end
    end
  end

  // calibration on wake after 25 pulses
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cal_on_wake_q <= 1'b0;
    end else if (sleep_ev) begin
      cal_on_wake_q <= (rise_cnt_q >= adcrd_pkg::RISE_SLP_CAL);
    end else if (wake_ev) begin
      cal_on_wake_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Ready and serial output pin
  // ****************************************************************
  // Pin drive; new result wins over a late shift edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ready_and_serial_out <= 1'b1;
    end else if (load_now) begin
      ready_and_serial_out <= 1'b0;
    end else if (upd_ev || sleep_ev ||
                 (state_q != adcrd_pkg::ST_RUN)) begin
      ready_and_serial_out <= 1'b1;
    end else if (rise_ev && data_ok_q) begin
      if (rise_cnt_q < adcrd_pkg::RISE_FORCE) begin
        ready_and_serial_out <=
          res_q[adcrd_pkg::IDX_MSB - rise_cnt_q[4:0]];
      end else if (rise_cnt_q == adcrd_pkg::RISE_FORCE) begin
        ready_and_serial_out <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Status outputs
  // ****************************************************************
  // conversion start pulse on a fixed cycle after wake
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conv_start_q <= 1'b0;
      sleep_q <= 1'b0;
      cal_busy_q <= 1'b0;
    end else begin
      conv_start_q <= (state_d == adcrd_pkg::ST_RUN) &&
        (cnt_clr || (state_q != adcrd_pkg::ST_RUN)) && !pwrup_done;
      sleep_q <= (state_d == adcrd_pkg::ST_SLEEP);
      cal_busy_q <= (state_d == adcrd_pkg::ST_CAL) ||
        (state_d == adcrd_pkg::ST_PWRUP);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence seq_cal_fall;
    (state_q == adcrd_pkg::ST_RUN) && data_ok_q && fall_ev &&
      (fall_cnt_q == adcrd_pkg::FALL_CAL);
  endsequence

  sequence seq_cal_end;
    (state_q == adcrd_pkg::ST_CAL) &&
      (cnt_q == adcrd_pkg::CNT_W'(CAL_CYC - 1));
  endsequence

  AST_PWRUP_READY: assert property (@(posedge clk) disable iff (!rst_n)
    pwrup_done |=> !ready_and_serial_out && (state_q == adcrd_pkg::ST_RUN))
    else $error("ready not low after power-up calibration");

  AST_PWRUP_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == adcrd_pkg::ST_PWRUP) && $past(state_q == adcrd_pkg::ST_PWRUP)
    |-> ready_and_serial_out)
    else $error("ready low during power-up");

  AST_SAT_POS: assert property (@(posedge clk) disable iff (!rst_n)
    load_now && ($signed(raw_sample) > adcrd_pkg::RAW_POS_FS)
    |=> res_q == adcrd_pkg::CODE_POS_FS)
    else $error("positive clip code wrong");

  AST_SAT_NEG: assert property (@(posedge clk) disable iff (!rst_n)
    load_now && ($signed(raw_sample) < adcrd_pkg::RAW_NEG_FS)
    |=> res_q == adcrd_pkg::CODE_NEG_FS)
    else $error("negative clip code wrong");

  AST_MSB_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
    rise_ev && data_ok_q && !load_now && !upd_ev && (rise_cnt_q == '0) &&
      (state_q == adcrd_pkg::ST_RUN) && !sleep_ev
    |=> ready_and_serial_out == res_q[23])
    else $error("first bit is not the MSB");

  AST_HOLD_LAST: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == adcrd_pkg::ST_RUN) && !rise_ev && !load_now && !upd_ev &&
      !sleep_ev |=> $stable(ready_and_serial_out))
    else $error("output changed without an edge or update");

  AST_FORCE_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
    rise_ev && data_ok_q && !load_now && (rise_cnt_q == adcrd_pkg::RISE_FORCE)
    |=> ready_and_serial_out [*2])
    else $error("25th edge did not force output high");

  AST_CAL_START: assert property (@(posedge clk) disable iff (!rst_n)
    seq_cal_fall |=> (state_q == adcrd_pkg::ST_CAL) && cal_busy_q)
    else $error("26th falling edge did not start calibration");

  AST_CAL_END: assert property (@(posedge clk) disable iff (!rst_n)
    seq_cal_end |=> !ready_and_serial_out && data_ok_q)
    else $error("ready not low after calibration");

  AST_SLEEP_ENTER: assert property (@(posedge clk) disable iff (!rst_n)
    sleep_ev |=> sleep_q ##1 ready_and_serial_out)
    else $error("high hold did not enter sleep");

  AST_SLEEP_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
    sleep_q && $past(sleep_q) |-> ready_and_serial_out)
    else $error("output low while asleep");

  AST_WAKE_CAL: assert property (@(posedge clk) disable iff (!rst_n)
    wake_ev && cal_on_wake_q |=> (state_q == adcrd_pkg::ST_CAL))
    else $error("wake did not calibrate");

  AST_WAKE_START: assert property (@(posedge clk) disable iff (!rst_n)
    wake_ev && !cal_on_wake_q |=> conv_start_q && !sleep_q)
    else $error("wake did not start a conversion");

  AST_UPDATE_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
    upd_ev && !sleep_ev && !cal_req |=> ready_and_serial_out && !data_ok_q)
    else $error("update did not drive output high");

endmodule // adcrd_top

// ### adcrd_end_marker_unused.sv
// Spare file, holds no logic

// ### adcrd_host.sv
// Host model that drives the shift clock and reads the serial output
`timescale 1ns/100ps
module adcrd_host (
  output logic sclk,
  input wire logic pin
);
  // ****************************************************************
  // Shift clock level
  // ****************************************************************
  // low at power-up
  initial sclk = 1'b0;

  // Hold the shift clock at a level (sleep entry and wakeup)
  // level control
  task automatic level(input logic v);
    sclk = v;
  endtask

  // ****************************************************************
  // Readout pulses, 48 ns period
  // ****************************************************************
  // sample before next rise
  task automatic shift(input int n, output logic [23:0] word);
    word = 24'h00_0000;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      #24;
      sclk = 1'b0;
      #23;
      // Only the data bits enter the word
      if (i < 24) begin
        word = {word[22:0], pin};
      end
      #1;
    end
  endtask
endmodule // adcrd_host

// ### tb_top.sv
// Self-checking bench for the converter readout control
`timescale 1ns/100ps
module tb_top;
  // ****************************************************************
  // Settings and signals
  // ****************************************************************
  localparam int unsigned P_PWR = 2000; // Short power-up count
  localparam int unsigned P_CONV = 3000; // Short conversion period
  localparam int unsigned P_CAL = 1500; // Short calibration time
  localparam int unsigned P_SLP = 200; // Short sleep hold
  typedef struct packed {
    logic [adcrd_pkg::RAW_W-1:0] raw;
    logic [adcrd_pkg::DATA_W-1:0] code;
  } adcrd_row_t;
  adcrd_row_t rows [8]; // Filter value beside its result code
  logic clk, rst_n, sclk, pin, conv_start_q, sleep_q, cal_busy_q;
  logic [adcrd_pkg::RAW_W-1:0] raw_sample; // Filter output to device
  logic [23:0] word; // Word read by the host
  int mismatches, n_checks, cycles;

  // Device under test with short counts
  adcrd_top #(.PWRUP_CYC(P_PWR), .CONV_CYC(P_CONV), .CAL_CYC(P_CAL),
    .UPD_CYC(100), .SLEEP_CYC(P_SLP)) dut (.clk(clk), .rst_n(rst_n),
    .sclk(sclk), .raw_sample(raw_sample), .ready_and_serial_out(pin),
    .conv_start_q(conv_start_q), .sleep_q(sleep_q),
    .cal_busy_q(cal_busy_q));
  // Host on the far side of the link
  adcrd_host host (.sclk(sclk), .pin(pin));

  // ****************************************************************
  // Clock, timeout and helpers
  // ****************************************************************
  // clock keeps running in sleep
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cut a hang short well beyond the planned run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic close_out();
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [23:0] seen,
      input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Wait for a level: 0 pin, 1 calibration, 2 sleep, 3 start pulse
  task automatic wait_sig(input int sel, input logic v, input int lim);
    logic [3:0] s;
    int k;
    k = 0;
    s = {conv_start_q, sleep_q, cal_busy_q, pin};
    while (s[sel] !== v && k < lim) begin
      @(negedge clk);
      k++;
      s = {conv_start_q, sleep_q, cal_busy_q, pin};
    end
    check("wait", 24'(s[sel]), 24'(v));
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rows = '{'{26'h100_0000, 24'h7F_FFFF}, '{26'h07F_FFFF, 24'h7F_FFFF},
      '{26'h000_0001, 24'h00_0001}, '{26'h000_0000, 24'h00_0000},
      '{26'h3FF_FFFF, 24'hFF_FFFF}, '{26'h380_0000, 24'h80_0000},
      '{26'h37F_FFFF, 24'h80_0000}, '{26'h200_0000, 24'h80_0000}};
    rst_n = 1'b0;
    raw_sample = rows[3].raw;
    cycles = 0;
    repeat (4) @(negedge clk);
    check("reset", 24'({pin, sleep_q, cal_busy_q, conv_start_q}), 24'h00_0008);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    check("pwr_cal", 24'(cal_busy_q), 24'h00_0001);
    wait_sig(0, 1'b0, P_PWR + 50);
    check("pwr_done", 24'(cal_busy_q), 24'h00_0000);
    // Table rows: load a value, read 25 bits
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      raw_sample = rows[i].raw;
      wait_sig(0, 1'b1, P_CONV + 50);
      wait_sig(0, 1'b0, P_CONV + 50);
      host.shift(25, word);
      check("code", word, rows[i].code);
      check("forced_high", 24'(pin), 24'h00_0001);
    end
    // Partial read holds the last bit until the update
    wait_sig(0, 1'b0, P_CONV + 50);
    host.shift(5, word);
    check("part", word, 24'h00_0010);
    repeat (50) @(negedge clk);
    check("hold", 24'(pin), 24'h00_0000);
    wait_sig(0, 1'b1, P_CONV + 50);
    wait_sig(0, 1'b0, 150);
    host.shift(26, word);
    repeat (8) @(negedge clk);
    check("cal", 24'({cal_busy_q, pin}), 24'h00_0003);
    wait_sig(0, 1'b0, P_CAL + 50);
    check("cal_end", 24'(cal_busy_q), 24'h00_0000);
    host.level(1'b1);
    repeat (P_SLP + 20) @(negedge clk);
    check("sleep", 24'({sleep_q, pin}), 24'h00_0003);
    @(negedge clk);
    raw_sample = rows[2].raw;
    host.level(1'b0);
    wait_sig(3, 1'b1, 12);
    check("wake", 24'({sleep_q, cal_busy_q}), 24'h00_0000);
    wait_sig(0, 1'b0, P_CONV + 50);
    host.shift(24, word);
    check("single", word, rows[2].code);
    // Sleep with calibration: 25 bits then high
    host.shift(1, word);
    host.level(1'b1);
    repeat (P_SLP + 20) @(negedge clk);
    check("sleep2", 24'({sleep_q, pin}), 24'h00_0003);
    host.level(1'b0);
    wait_sig(1, 1'b1, 12);
    wait_sig(0, 1'b0, P_CAL + P_CONV + 50);
    check("wake_cal", 24'(cal_busy_q), 24'h00_0000);
    close_out();
  end
endmodule // tb_top
